// *** rtl/tw_pkg.sv ***
package tw_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL_A  = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_CLEAR   = 8'h08;
  localparam logic [7:0] ADDR_ENABLE  = 8'h0c;
  localparam logic [7:0] ADDR_STATE   = 8'h10;
  // control register layout
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
  localparam int         ACT_A_LSB    = 6;
  localparam int         ACT_B_LSB    = 4;
  localparam int         MODE_LSB     = 0;
  localparam logic [3:0] MODE_RESERVED = 4'hd;
  // event bits of status, clear and enable
  localparam int         EVT_OVF      = 0;
  localparam int         EVT_MATCH_A  = 1;
  localparam int         EVT_MATCH_B  = 2;
  localparam int         EVT_UPDATE   = 3;
  localparam logic [3:0] EVT_RESET    = 4'h0;
  // counter landmarks
  localparam logic [15:0] TOP_MAX     = 16'hffff;
  localparam logic [15:0] TOP_8BIT    = 16'h00ff;
  localparam logic [15:0] TOP_9BIT    = 16'h01ff;
  localparam logic [15:0] TOP_10BIT   = 16'h03ff;
  localparam logic [15:0] BOTTOM      = 16'h0000;
  // output action codes
  localparam logic [1:0] ACT_OFF      = 2'h0;
  localparam logic [1:0] ACT_TOGGLE   = 2'h1;
  localparam logic [1:0] ACT_CLEAR    = 2'h2;
  localparam logic [1:0] ACT_SET      = 2'h3;
  // waveform families
  typedef enum logic [3:0] {
    KIND_NONPWM = 4'h1, KIND_FAST = 4'h2, KIND_DUAL = 4'h4, KIND_RSVD = 4'h8
  } tw_kind_type;
  // counter points for buffer update and overflow
  typedef enum logic [3:0] {
    PT_IMMED = 4'h1, PT_TOP = 4'h2, PT_BOTTOM = 4'h4, PT_MAX = 4'h8
  } tw_point_type;
endpackage

// *** rtl/tw_mode_decode.sv ***
`timescale 1ns/1ns
module tw_mode_decode (
  // mode and top sources
  input  wire logic [3:0]          mode_in,
  input  wire logic [15:0]         compare_a_in,
  input  wire logic [15:0]         capture_in,
  // decoded behaviour
  output tw_pkg::tw_kind_type      kind_out,
  output logic [15:0]              top_value_out,
  output tw_pkg::tw_point_type     update_point_out,
  output tw_pkg::tw_point_type     overflow_point_out
);
  // fixed tops of 8, 9 and 10 bits
  wire logic [15:0] fixed_top = (mode_in[1:0] == 2'h1) ? tw_pkg::TOP_8BIT :
                                (mode_in[1:0] == 2'h2) ? tw_pkg::TOP_9BIT : tw_pkg::TOP_10BIT;

  // mode table
  always_comb begin
    kind_out           = tw_pkg::KIND_NONPWM;
    top_value_out      = tw_pkg::TOP_MAX;
    update_point_out   = tw_pkg::PT_IMMED;
    overflow_point_out = tw_pkg::PT_MAX;
    case (mode_in)
      4'h0: top_value_out = tw_pkg::TOP_MAX;
      4'h4: top_value_out = compare_a_in;
      4'hc: top_value_out = capture_in;
      4'h1, 4'h2, 4'h3, 4'ha, 4'hb: begin
        kind_out           = tw_pkg::KIND_DUAL;
        top_value_out      = mode_in[3] ? (mode_in[0] ? compare_a_in : capture_in) : fixed_top;
        update_point_out   = tw_pkg::PT_TOP;
        overflow_point_out = tw_pkg::PT_BOTTOM;
      end
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: begin
        kind_out           = tw_pkg::KIND_FAST;
        top_value_out      = mode_in[3] ? (mode_in[0] ? compare_a_in : capture_in) : fixed_top;
        update_point_out   = tw_pkg::PT_TOP;
        overflow_point_out = tw_pkg::PT_TOP;
      end
      4'h8, 4'h9: begin
        kind_out           = tw_pkg::KIND_DUAL;
        top_value_out      = mode_in[0] ? compare_a_in : capture_in;
        update_point_out   = tw_pkg::PT_BOTTOM;
        overflow_point_out = tw_pkg::PT_BOTTOM;
      end
      default: kind_out = tw_pkg::KIND_RSVD;
    endcase
  end
endmodule // tw_mode_decode

// *** rtl/tw_wave_chan.sv ***
`timescale 1ns/1ns
module tw_wave_chan #(
  parameter bit PWM_TOGGLE_OK = 1'b1
) (
  // clock and reset
  input  wire logic                clock_in,
  input  wire logic                reset_n_in,
  // counter view
  input  wire logic                tick_in,
  input  wire logic                count_up_in,
  input  wire logic                at_top_in,
  input  wire logic                match_in,
  // configuration
  input  wire logic [1:0]          action_in,
  input  wire tw_pkg::tw_kind_type kind_in,
  input  wire logic                mode_top_bit_in,
  input  wire logic                pin_dir_in,
  // pin side
  output logic                     wave_out,
  output logic                     connected_out,
  output logic                     pin_oe_out
);
  logic next_wave;

  // connection and driver enable
  wire logic pwm       = (kind_in == tw_pkg::KIND_FAST) || (kind_in == tw_pkg::KIND_DUAL);
  wire logic toggle    = (action_in == tw_pkg::ACT_TOGGLE);
  wire logic toggle_ok = !pwm || (mode_top_bit_in && PWM_TOGGLE_OK);
  assign connected_out = (action_in != tw_pkg::ACT_OFF) && (!toggle || toggle_ok);
  assign pin_oe_out    = connected_out && pin_dir_in;

  wire logic fast_top  = tick_in && (kind_in == tw_pkg::KIND_FAST) && action_in[1] && at_top_in;
  wire logic match_hit = tick_in && match_in && (kind_in != tw_pkg::KIND_RSVD);
  wire logic dual_lvl  = count_up_in ? action_in[0] : !action_in[0];

  assign next_wave = !connected_out ? wave_out :
                     fast_top ? !action_in[0] :
                     !match_hit ? wave_out :
                     toggle ? !wave_out :
                     (kind_in == tw_pkg::KIND_DUAL) ? dual_lvl : action_in[0];

  // wave register
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wave_out <= 1'b0;
    end else begin
      wave_out <= next_wave;
    end
  end
endmodule // tw_wave_chan

// *** rtl/tw_top.sv ***
`timescale 1ns/1ns
// Behaviour
// - nonzero channel A action routes its wave onto the pin, except pwm action 01 without top bit
// - nonzero channel B action routes its wave onto the pin, except action 01 in pwm modes
// - pin driver enabled only when its direction bit is set
// - non-pwm match: 00 off, 01 toggle, 10 low, 11 high
// - fast pwm: 10 clear on match set at top; 11 reverse
// - pwm action 01: off unless top bit; then A toggles, B off
// - fast pwm compare equal top, actions 10 and 11: match ignored, top action kept
// - dual slope: 10 clear up, set down; 11 reverse
// - mode is two high bits from outside plus two low; 13 reserved
// - phase correct tops fixed or from capture or A; update top, overflow bottom
// - fast pwm tops fixed or from capture or A; update and overflow at top
// - modes 8 and 9: top from capture or A; update and overflow at bottom
// - normal top max; clear-on-match top A or capture; immediate, max
module tw_top (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  // wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  // counter and compare view
  input  wire logic        timer_tick_in,
  input  wire logic [15:0] count_value_in,
  input  wire logic        count_up_in,
  input  wire logic [15:0] compare_value_a_in,
  input  wire logic [15:0] compare_value_b_in,
  input  wire logic [15:0] capture_value_reg_in,
  input  wire logic [1:0]  wave_mode_high_bits_in,
  // pin direction bits
  input  wire logic        pin_dir_a_in,
  input  wire logic        pin_dir_b_in,
  // mode results
  output logic [15:0]      top_value_out,
  output logic             buffer_update_out,
  output logic             update_immediate_out,
  output logic             overflow_flag_set_out,
  output logic             dual_slope_out,
  // compare pins
  output logic             chan_a_wave_out,
  output logic             chan_a_pin_oe_out,
  output logic             chan_a_connected_out,
  output logic             chan_b_wave_out,
  output logic             chan_b_pin_oe_out,
  output logic             chan_b_connected_out,
  // interrupt
  output logic             irq_out
);
  // registers
  logic [7:0]  timer_control_a;
  logic [3:0]  status;
  logic [3:0]  enable;
  logic [3:0]  next_status;
  logic [7:0]  next_control;

  // decoded mode
  tw_pkg::tw_kind_type  kind;
  tw_pkg::tw_point_type upd_point;
  tw_pkg::tw_point_type ovf_point;
  logic [15:0]          top_value;

  // per channel arrays
  logic [1:0]  action [2];
  logic [15:0] compare [2];
  logic [1:0]  pin_dir;
  logic [1:0]  match;
  logic [1:0]  wave;
  logic [1:0]  connected;
  logic [1:0]  pin_oe;

  // control fields
  wire logic [1:0] chan_a_output_action = timer_control_a[tw_pkg::ACT_A_LSB +: 2];
  wire logic [1:0] chan_b_output_action = timer_control_a[tw_pkg::ACT_B_LSB +: 2];
  wire logic [1:0] wave_mode_low_bits   = timer_control_a[tw_pkg::MODE_LSB +: 2];
  wire logic [3:0] wave_mode_field      = {wave_mode_high_bits_in, wave_mode_low_bits};
  wire logic       wave_mode_top_bit    = wave_mode_field[3];

  // bus decode
  wire logic req      = wb_cyc_in && wb_stb_in;
  wire logic req_new  = req && !wb_ack_out;
  wire logic wr_fire  = req && wb_we_in && wb_ack_out && wb_sel_in[0];
  wire logic hit_ctrl = (wb_adr_in == tw_pkg::ADDR_CTRL_A);
  wire logic hit_stat = (wb_adr_in == tw_pkg::ADDR_STATUS);
  wire logic hit_clr  = (wb_adr_in == tw_pkg::ADDR_CLEAR);
  wire logic hit_en   = (wb_adr_in == tw_pkg::ADDR_ENABLE);
  wire logic hit_st   = (wb_adr_in == tw_pkg::ADDR_STATE);
  wire logic wr_ctrl  = wr_fire && hit_ctrl;
  wire logic wr_en    = wr_fire && hit_en;
  wire logic [3:0] clear_mask = (wr_fire && hit_clr) ? wb_dat_in[3:0] : 4'h0;

  // read data selection, unmapped reads zero
  wire logic [31:0] rd_data =
    hit_ctrl ? {24'h000000, timer_control_a} :
    hit_stat ? {28'h0000000, status} :
    hit_en   ? {28'h0000000, enable} :
    hit_st   ? {24'h000000, wave_mode_field, connected, wave} : 32'h00000000;

  assign next_control = wb_dat_in[7:0] & tw_pkg::CTRL_A_WMASK;

  // mode table
  tw_mode_decode u_decode (
    .mode_in            (wave_mode_field),
    .compare_a_in       (compare_value_a_in),
    .capture_in         (capture_value_reg_in),
    .kind_out           (kind),
    .top_value_out      (top_value),
    .update_point_out   (upd_point),
    .overflow_point_out (ovf_point)
  );

  // counter landmarks
  wire logic at_top    = (count_value_in == top_value);
  wire logic at_bottom = (count_value_in == tw_pkg::BOTTOM);
  wire logic at_max    = (count_value_in == tw_pkg::TOP_MAX);

  wire logic hit_upd = timer_tick_in &&
    (((upd_point == tw_pkg::PT_TOP) && at_top) ||
     ((upd_point == tw_pkg::PT_BOTTOM) && at_bottom));
  wire logic hit_ovf = timer_tick_in &&
    (((ovf_point == tw_pkg::PT_TOP) && at_top) ||
     ((ovf_point == tw_pkg::PT_BOTTOM) && at_bottom) ||
     ((ovf_point == tw_pkg::PT_MAX) && at_max));

  // channel wiring
  assign action[0]  = chan_a_output_action;
  assign action[1]  = chan_b_output_action;
  assign compare[0] = compare_value_a_in;
  assign compare[1] = compare_value_b_in;
  assign pin_dir    = {pin_dir_b_in, pin_dir_a_in};

  // one wave unit per compare channel
  for (genvar gi = 0; gi < 2; gi++) begin : g_chan
    assign match[gi] = (count_value_in == compare[gi]);
    tw_wave_chan #(
      .PWM_TOGGLE_OK (gi == 0)
    ) u_chan (
      .clock_in        (clock_in),
      .reset_n_in      (reset_n_in),
      .tick_in         (timer_tick_in),
      .count_up_in     (count_up_in),
      .at_top_in       (at_top),
      .match_in        (match[gi]),
      .action_in       (action[gi]),
      .kind_in         (kind),
      .mode_top_bit_in (wave_mode_top_bit),
      .pin_dir_in      (pin_dir[gi]),
      .wave_out        (wave[gi]),
      .connected_out   (connected[gi]),
      .pin_oe_out      (pin_oe[gi])
    );
  end

  // pin outputs
  assign chan_a_wave_out      = wave[0];
  assign chan_b_wave_out      = wave[1];
  assign chan_a_connected_out = connected[0];
  assign chan_b_connected_out = connected[1];
  assign chan_a_pin_oe_out    = pin_oe[0];
  assign chan_b_pin_oe_out    = pin_oe[1];

  // sticky events, set beats clear
  wire logic [3:0] events = {hit_upd, timer_tick_in && match[1],
                             timer_tick_in && match[0], hit_ovf};
  assign next_status = (status & ~clear_mask) | events;
  assign irq_out     = |(status & enable);

  // bus handshake and read data
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      wb_ack_out <= req_new;
      wb_dat_out <= req_new ? rd_data : 32'h00000000;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      timer_control_a <= tw_pkg::CTRL_A_RESET;
    end else if (wr_ctrl) begin
      timer_control_a <= next_control;
    end
  end

  // status and enable
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      status <= tw_pkg::EVT_RESET;
      enable <= tw_pkg::EVT_RESET;
    end else begin
      status <= next_status;
      if (wr_en) begin
        enable <= wb_dat_in[3:0];
      end
    end
  end

  // registered mode results
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      top_value_out         <= tw_pkg::TOP_MAX;
      buffer_update_out     <= 1'b0;
      update_immediate_out  <= 1'b1;
      overflow_flag_set_out <= 1'b0;
      dual_slope_out        <= 1'b0;
    end else begin
      top_value_out         <= top_value;
      buffer_update_out     <= hit_upd;
      update_immediate_out  <= (upd_point == tw_pkg::PT_IMMED);
      overflow_flag_set_out <= hit_ovf;
      dual_slope_out        <= (kind == tw_pkg::KIND_DUAL);
    end
  end

  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  // shorthand for checks
  wire logic tick_a = timer_tick_in && match[0];
  wire logic tick_b = timer_tick_in && match[1];
  wire logic fast   = (kind == tw_pkg::KIND_FAST);
  wire logic dual   = (kind == tw_pkg::KIND_DUAL);
  wire logic nonpwm = (kind == tw_pkg::KIND_NONPWM);

  property p_route_a;
    (chan_a_output_action != tw_pkg::ACT_OFF) && nonpwm |-> chan_a_connected_out;
  endproperty
  a_route_a: assert property (p_route_a) else $error("chan a not routed");

  property p_route_b;
    (chan_b_output_action != tw_pkg::ACT_OFF) && !dual && !fast |-> chan_b_connected_out;
  endproperty
  a_route_b: assert property (p_route_b) else $error("chan b not routed");

  property p_pin_oe;
    chan_a_pin_oe_out || chan_b_pin_oe_out |->
      (!chan_a_pin_oe_out || (pin_dir_a_in && chan_a_connected_out)) &&
      (!chan_b_pin_oe_out || (pin_dir_b_in && chan_b_connected_out));
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("driver on without direction");

  property p_nonpwm_toggle;
    tick_a && nonpwm && (chan_a_output_action == tw_pkg::ACT_TOGGLE)
      |=> chan_a_wave_out != $past(chan_a_wave_out);
  endproperty
  a_nonpwm_toggle: assert property (p_nonpwm_toggle) else $error("no toggle");

  property p_nonpwm_set;
    tick_b && nonpwm && (chan_b_output_action == tw_pkg::ACT_SET) |=> chan_b_wave_out;
  endproperty
  a_nonpwm_set: assert property (p_nonpwm_set) else $error("no set on match");

  property p_fast_top;
    timer_tick_in && fast && at_top && (chan_a_output_action == tw_pkg::ACT_CLEAR)
      |=> chan_a_wave_out;
  endproperty
  a_fast_top: assert property (p_fast_top) else $error("no set at top");

  property p_pwm_b_toggle;
    (fast || dual) && (chan_b_output_action == tw_pkg::ACT_TOGGLE) |-> !chan_b_connected_out;
  endproperty
  a_pwm_b_toggle: assert property (p_pwm_b_toggle) else $error("b toggle connected");

  property p_pwm_a_toggle;
    tick_a && (fast || dual) && wave_mode_top_bit &&
      (chan_a_output_action == tw_pkg::ACT_TOGGLE)
      |=> chan_a_wave_out != $past(chan_a_wave_out);
  endproperty
  a_pwm_a_toggle: assert property (p_pwm_a_toggle) else $error("a pwm toggle missing");

  property p_fast_ignore;
    tick_a && fast && at_top && (chan_a_output_action == tw_pkg::ACT_SET) |=> !chan_a_wave_out;
  endproperty
  a_fast_ignore: assert property (p_fast_ignore) else $error("match at top not ignored");

  property p_dual_down;
    tick_b && dual && !count_up_in && (chan_b_output_action == tw_pkg::ACT_CLEAR)
      |=> chan_b_wave_out;
  endproperty
  a_dual_down: assert property (p_dual_down) else $error("no set on down match");

  property p_dual_up;
    tick_a && dual && count_up_in && (chan_a_output_action == tw_pkg::ACT_CLEAR)
      |=> !chan_a_wave_out;
  endproperty
  a_dual_up: assert property (p_dual_up) else $error("no clear on up match");

  property p_rsvd_hold;
    (wave_mode_field == tw_pkg::MODE_RESERVED) |=> $stable(wave);
  endproperty
  a_rsvd_hold: assert property (p_rsvd_hold) else $error("reserved mode moved wave");

  property p_phase_top;
    (wave_mode_field == 4'h1) |=> (top_value_out == tw_pkg::TOP_8BIT);
  endproperty
  a_phase_top: assert property (p_phase_top) else $error("mode 1 top wrong");

  property p_fast_ovf;
    timer_tick_in && fast && at_top |=> overflow_flag_set_out && buffer_update_out;
  endproperty
  a_fast_ovf: assert property (p_fast_ovf) else $error("fast top events missing");

  property p_pfc_bottom;
    timer_tick_in && (wave_mode_field == 4'h8) && at_bottom
      |=> overflow_flag_set_out && buffer_update_out && status[tw_pkg::EVT_OVF];
  endproperty
  a_pfc_bottom: assert property (p_pfc_bottom) else $error("bottom events missing");

  property p_normal;
    (wave_mode_field == 4'h0) |=> (top_value_out == tw_pkg::TOP_MAX) && update_immediate_out;
  endproperty
  a_normal: assert property (p_normal) else $error("normal mode wrong");

  property p_ctrl_write;
    wr_ctrl |=> (timer_control_a == ($past(wb_dat_in[7:0]) & tw_pkg::CTRL_A_WMASK))
            && (timer_control_a[3:2] == 2'h0);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write wrong");

  property p_wb_ack;
    req_new |=> wb_ack_out ##1 !wb_ack_out;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("ack timing wrong");

  property p_match_sticky;
    tick_a |=> status[tw_pkg::EVT_MATCH_A];
  endproperty
  a_match_sticky: assert property (p_match_sticky) else $error("match a not flagged");

  // main scenarios
  c_fast_pwm: cover property (fast && chan_a_connected_out ##1 $changed(chan_a_wave_out));
  c_dual_pwm: cover property (dual && tick_b ##1 $changed(chan_b_wave_out));
  c_irq:      cover property ($rose(irq_out));
  c_toggle:   cover property (nonpwm && tick_a && chan_a_output_action == tw_pkg::ACT_TOGGLE);
endmodule // tw_top

// *** testbench/tw_pin_model.sv ***
`timescale 1ns/1ns
// port pin seen from outside the block
module tw_pin_model (
  // clock
  input  wire logic clock_in,
  // pin drive
  input  wire logic wave_in,
  input  wire logic oe_in,
  // pad level
  output logic      pad_out
);
  logic float_q = 1'b0; // level shown while released

  // released pad flips every cycle so a stale level never passes
  always_ff @(posedge clock_in) begin
    float_q <= ~pad_out;
  end

  assign pad_out = oe_in ? wave_in : float_q;
endmodule // tw_pin_model

// *** testbench/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  // bench signals
  logic        clock_in   = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr  = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic        ack, tick = 1'b0, up = 1'b1, dir_a = 1'b1, dir_b = 1'b1;
  logic [15:0] cnt = 16'h0, cmp_a = 16'h0040, cmp_b = 16'h00ff, cap = 16'h0100, top_v;
  logic [1:0]  hi   = 2'h0;
  logic [3:0]  mode = 4'h0;
  logic        bufu, immed, ovf, dual, wa, oea, ca, wb_w, oeb, cb, irq, pad_a, pad_b;
  int          num_errors = 0, comparisons = 0, seed = 71527;
  logic [31:0] exp_q[$];
  // wave rows: mode, actions a b, up and count-at-ff, then conn a b and wave a b
  logic [15:0] rows [17] = '{16'h0f8e, 16'h0fcf, 16'h0a8d, 16'h05cc, 16'h058e, 16'h0082,
    16'h5a8c, 16'h5acf, 16'h5fcc, 16'h5f8e, 16'h1a8c, 16'h1a0e, 16'h1f0c, 16'h1f8e,
    16'h1582, 16'ha588, 16'ha58a};
  // event rows: mode, count, expected status
  logic [3:0]  pm [5] = '{4'h0, 4'h5, 4'h8, 4'h1, 4'h1};
  logic [15:0] pc [5] = '{16'hffff, 16'h00ff, 16'h0000, 16'h0000, 16'h00ff};
  logic [3:0]  ps [5] = '{4'h1, 4'hd, 4'h9, 4'h1, 4'hc};

  tw_top uut (.clock_in(clock_in), .reset_n_in(reset_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .timer_tick_in(tick), .count_value_in(cnt), .count_up_in(up),
    .compare_value_a_in(cmp_a), .compare_value_b_in(cmp_b), .capture_value_reg_in(cap),
    .wave_mode_high_bits_in(hi), .pin_dir_a_in(dir_a), .pin_dir_b_in(dir_b),
    .top_value_out(top_v), .buffer_update_out(bufu), .update_immediate_out(immed),
    .overflow_flag_set_out(ovf), .dual_slope_out(dual), .chan_a_wave_out(wa),
    .chan_a_pin_oe_out(oea), .chan_a_connected_out(ca), .chan_b_wave_out(wb_w),
    .chan_b_pin_oe_out(oeb), .chan_b_connected_out(cb), .irq_out(irq));
  tw_pin_model pin_a (.clock_in(clock_in), .wave_in(wa), .oe_in(oea), .pad_out(pad_a));
  tw_pin_model pin_b (.clock_in(clock_in), .wave_in(wb_w), .oe_in(oeb), .pad_out(pad_b));

  // clock
  always #20 clock_in = ~clock_in;

  // counted compare of a port value
  task automatic compare_sig(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // read data against the oldest note
  task automatic compare_read(input logic [31:0] got);
    compare_sig(got, exp_q.size() != 0 ? exp_q.pop_front() : 32'hxxxx_xxxx);
  endtask

  // watcher of read answers
  always @(posedge clock_in) begin
    if (ack === 1'b1 && we === 1'b0) begin
      compare_read(rdat);
    end
  end

  // one classic bus cycle, held until ack
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock_in);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clock_in);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n >= 100) num_errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wb_read(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb_cycle(1'b0, a, 32'h0);
  endtask

  // mode and actions into control and high bits
  task automatic set_cfg(input logic [3:0] m, input logic [1:0] aa, input logic [1:0] ab);
    mode = m;
    hi <= m[3:2];
    wb_cycle(1'b1, tw_pkg::ADDR_CTRL_A, {24'h0, aa, ab, 2'h0, m[1:0]});
  endtask

  // one counter step
  task automatic step(input logic [15:0] c, input logic u);
    @(posedge clock_in);
    tick <= 1'b1;
    cnt  <= c;
    up   <= u;
    @(posedge clock_in);
    tick <= 1'b0;
    @(posedge clock_in);
  endtask

  // r is conn a, conn b, wave a, wave b
  task automatic chk_state(input logic [3:0] r);
    wb_read(tw_pkg::ADDR_STATE, {24'h0, mode, r[2], r[3], r[0], r[1]});
    compare_sig(32'(oea), 32'(r[3] & dir_a));
    compare_sig(32'(oeb), 32'(r[2] & dir_b));
    if (oea === 1'b1) compare_sig(32'(pad_a), 32'(r[1]));
    if (oeb === 1'b1) compare_sig(32'(pad_b), 32'(r[0]));
  endtask

  function automatic logic [15:0] exp_top(input int m);
    case (m)
      1, 5: return tw_pkg::TOP_8BIT;
      2, 6: return tw_pkg::TOP_9BIT;
      3, 7: return tw_pkg::TOP_10BIT;
      4, 9, 11, 15: return cmp_a;
      8, 10, 12, 14: return cap;
      default: return tw_pkg::TOP_MAX;
    endcase
  endfunction

  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clock_in);
    reset_n_in <= 1'b1;
    wb_read(tw_pkg::ADDR_CTRL_A, 32'h0);
    wb_read(tw_pkg::ADDR_STATUS, 32'h0);
    wb_read(tw_pkg::ADDR_ENABLE, 32'h0);
    wb_cycle(1'b1, tw_pkg::ADDR_CTRL_A, 32'hff);
    wb_read(tw_pkg::ADDR_CTRL_A, {24'h0, tw_pkg::CTRL_A_WMASK});
    wb_read(8'h20, 32'h0);
    // every mode with random top sources
    for (int m = 0; m < 16; m++) begin
      cap   <= 16'($random(seed));
      cmp_a <= 16'($random(seed));
      set_cfg(4'(m), 2'h0, 2'h0);
      repeat (2) @(posedge clock_in);
      compare_sig(32'(top_v), 32'(exp_top(m)));
      compare_sig(32'(dual), 32'(m inside {1, 2, 3, 8, 9, 10, 11}));
      // reserved mode 13 has no update point and reports immediate
      compare_sig(32'(immed), 32'(m inside {0, 4, 12, 13}));
      wb_read(tw_pkg::ADDR_STATE, {24'h0, 4'(m), 4'h0});
    end
    cap   <= 16'h0100;
    cmp_a <= 16'h0040;
    // output actions per mode family
    for (int i = 0; i < 17; i++) begin
      dir_b <= (i != 2);
      set_cfg(rows[i][15:12], rows[i][11:10], rows[i][9:8]);
      step(rows[i][6] ? 16'h00ff : 16'h0040, rows[i][7]);
      chk_state(rows[i][3:0]);
    end
    // update and overflow points
    for (int i = 0; i < 5; i++) begin
      set_cfg(pm[i], 2'h0, 2'h0);
      wb_cycle(1'b1, tw_pkg::ADDR_CLEAR, 32'hf);
      step(pc[i], 1'b1);
      // one-cycle pulses still stand at the edge after the tick
      compare_sig(32'(ovf), 32'(ps[i][tw_pkg::EVT_OVF]));
      compare_sig(32'(bufu), 32'(ps[i][tw_pkg::EVT_UPDATE]));
      wb_read(tw_pkg::ADDR_STATUS, {28'h0, ps[i]});
    end
    // interrupt raise, mask and clear
    wb_cycle(1'b1, tw_pkg::ADDR_ENABLE, 32'h8);
    @(posedge clock_in);
    compare_sig(32'(irq), 32'h1);
    wb_cycle(1'b1, tw_pkg::ADDR_ENABLE, 32'h1);
    @(posedge clock_in);
    compare_sig(32'(irq), 32'h0);
    wb_cycle(1'b1, tw_pkg::ADDR_ENABLE, 32'h8);
    wb_cycle(1'b1, tw_pkg::ADDR_CLEAR, 32'h8);
    @(posedge clock_in);
    compare_sig(32'(irq), 32'h0);
    wb_cycle(1'b1, tw_pkg::ADDR_STATUS, 32'h0);
    wb_read(tw_pkg::ADDR_STATUS, 32'h4);
    wb_read(tw_pkg::ADDR_CLEAR, 32'h0);
    wb_read(tw_pkg::ADDR_ENABLE, 32'h8);
    repeat (2) @(posedge clock_in);
    complete_run();
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clock_in);
    num_errors++;
    complete_run();
  end
endmodule // tb_top
